// *** src/cxr_routing.sv ***
// Crossbar peripheral routing enables: two routing registers and the
// per-function pin-route enables that they produce.
// Assumes a synchronous special-function-register bus and that the global
// crossbar enable, the slave-select mode and the skip logic live elsewhere.
//
// Function
// - Bit A7 routes comparator 1 asynchronous output.
// - Bit A6 routes comparator 1 synchronous output.
// - Bit A5 routes comparator 0 asynchronous output.
// - Bit A4 routes comparator 0 synchronous output.
// - Bit A3 routes both two-wire bus signals.
// - Bit A2 routes serial peripheral, three or four pins.
// - Bit A1 routes fieldbus pair to P0.6/P0.7.
// - Bit A0 routes async serial to P0.4/P0.5.
// - Bit B7 routes timer 1 input.
// - Bit B6 routes timer 0 input.
// - Bit B5 routes counter external clock input.
// - Field B4:2 routes that many channels upward; code 7 routes none.
// - Bit B1 drives system clock out.
// - Nothing routed until global crossbar enable set.
// - Paired peripherals get both signals together.
// - Select pin routed only in 4-wire mode.
`timescale 1ns/1ps

module cxr_routing import cxr_pkg::*; (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input wire logic crossbar_global_on,
	input wire logic [1:0] slave_select_mode,
	output logic pins_port_input_only,
	output logic cmp1_async_out_route,
	output logic cmp1_sync_out_route,
	output logic cmp0_async_out_route,
	output logic cmp0_sync_out_route,
	output logic twowire_data_route,
	output logic twowire_clock_route,
	output logic serial_periph_route,
	output logic serial_select_route,
	output logic fieldbus_tx_route,
	output logic fieldbus_rx_route,
	output logic async_serial_tx_route,
	output logic async_serial_rx_route,
	output logic timer1_input_route,
	output logic timer0_input_route,
	output logic counter_ext_clock_route,
	output logic [CXR_CHANNELS-1:0] counter_channel_pin_n_route,
	output logic sysclock_out_route
);

	typedef struct packed {
		logic [7:0] route_a;
		logic [7:0] route_b;
		logic [7:0] rdata;
		logic port_only;
		logic cmp1_async;
		logic cmp1_sync;
		logic cmp0_async;
		logic cmp0_sync;
		logic tw_data;
		logic tw_clock;
		logic sp_route;
		logic sp_select;
		logic fb_tx;
		logic fb_rx;
		logic as_tx;
		logic as_rx;
		logic tmr1;
		logic tmr0;
		logic ext_clock;
		logic [CXR_CHANNELS-1:0] chan;
		logic sysclock;
	} cxr_state_t;

	cxr_state_t st;
	cxr_state_t next_st;
	logic [CXR_CHANNELS-1:0] next_chan_mask;
	logic [CXR_CHAN_W-1:0] next_chan_count;

	// A routing enable only reaches the pins while the crossbar is on.
	function automatic logic gate(input logic enable_bit, input logic global_on);
		return enable_bit & global_on;
	endfunction

	// The count is taken from the bus and the stored register rather than from
	// next_st, so the decoder does not close a loop through the state process.
	assign next_chan_count = (sfr_wr && sfr_addr == CXR_ROUTE_B_ADDR)
		? sfr_wdata[CXR_B_CHAN_HI:CXR_B_CHAN_LO] : st.route_b[CXR_B_CHAN_HI:CXR_B_CHAN_LO];

	cxr_channel_decode cxr_channel_decode_inst (
		.count(next_chan_count),
		.mask(next_chan_mask)
	);

	always_comb begin
		next_st = st;
		if (sfr_wr && sfr_addr == CXR_ROUTE_A_ADDR) begin
			next_st.route_a = sfr_wdata;
		end
		// The spare bit is stored as written; it steers nothing.
		if (sfr_wr && sfr_addr == CXR_ROUTE_B_ADDR) begin
			next_st.route_b = sfr_wdata;
		end
		if (sfr_rd) begin
			case (sfr_addr)
				CXR_ROUTE_A_ADDR: next_st.rdata = st.route_a;
				CXR_ROUTE_B_ADDR: next_st.rdata = st.route_b;
				default: next_st.rdata = CXR_UNMAPPED_DATA;
			endcase
		end
		// Outputs follow the register value written in the same cycle, so the
		// route changes on the very edge that takes the write.
		next_st.port_only = ~crossbar_global_on;
		next_st.cmp1_async = gate(next_st.route_a[CXR_A_CMP1_ASYNC], crossbar_global_on);
		next_st.cmp1_sync = gate(next_st.route_a[CXR_A_CMP1_SYNC], crossbar_global_on);
		next_st.cmp0_async = gate(next_st.route_a[CXR_A_CMP0_ASYNC], crossbar_global_on);
		next_st.cmp0_sync = gate(next_st.route_a[CXR_A_CMP0_SYNC], crossbar_global_on);
		next_st.tw_data = gate(next_st.route_a[CXR_A_TWOWIRE], crossbar_global_on);
		next_st.tw_clock = gate(next_st.route_a[CXR_A_TWOWIRE], crossbar_global_on);
		next_st.sp_route = gate(next_st.route_a[CXR_A_SERIAL_PERIPH], crossbar_global_on);
		next_st.sp_select = gate(next_st.route_a[CXR_A_SERIAL_PERIPH], crossbar_global_on)
			& (slave_select_mode != CXR_SELECT_3WIRE);
		next_st.fb_tx = gate(next_st.route_a[CXR_A_FIELDBUS], crossbar_global_on);
		next_st.fb_rx = gate(next_st.route_a[CXR_A_FIELDBUS], crossbar_global_on);
		next_st.as_tx = gate(next_st.route_a[CXR_A_ASYNC_SERIAL], crossbar_global_on);
		next_st.as_rx = gate(next_st.route_a[CXR_A_ASYNC_SERIAL], crossbar_global_on);
		next_st.tmr1 = gate(next_st.route_b[CXR_B_TIMER1], crossbar_global_on);
		next_st.tmr0 = gate(next_st.route_b[CXR_B_TIMER0], crossbar_global_on);
		next_st.ext_clock = gate(next_st.route_b[CXR_B_EXT_CLOCK], crossbar_global_on);
		next_st.chan = crossbar_global_on ? next_chan_mask : '0;
		next_st.sysclock = gate(next_st.route_b[CXR_B_SYSCLOCK], crossbar_global_on);
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st <= '0;
			st.route_a <= CXR_ROUTE_A_RESET;
			st.route_b <= CXR_ROUTE_B_RESET;
			st.rdata <= CXR_RDATA_RESET;
			st.port_only <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign sfr_rdata = st.rdata;
	assign pins_port_input_only = st.port_only;
	assign cmp1_async_out_route = st.cmp1_async;
	assign cmp1_sync_out_route = st.cmp1_sync;
	assign cmp0_async_out_route = st.cmp0_async;
	assign cmp0_sync_out_route = st.cmp0_sync;
	assign twowire_data_route = st.tw_data;
	assign twowire_clock_route = st.tw_clock;
	assign serial_periph_route = st.sp_route;
	assign serial_select_route = st.sp_select;
	assign fieldbus_tx_route = st.fb_tx;
	assign fieldbus_rx_route = st.fb_rx;
	assign async_serial_tx_route = st.as_tx;
	assign async_serial_rx_route = st.as_rx;
	assign timer1_input_route = st.tmr1;
	assign timer0_input_route = st.tmr0;
	assign counter_ext_clock_route = st.ext_clock;
	assign counter_channel_pin_n_route = st.chan;
	assign sysclock_out_route = st.sysclock;

	// Checks on the routing behaviour.

	sequence s_write_a;
		sfr_wr && sfr_addr == CXR_ROUTE_A_ADDR && crossbar_global_on;
	endsequence

	sequence s_write_b;
		sfr_wr && sfr_addr == CXR_ROUTE_B_ADDR && crossbar_global_on;
	endsequence

	a_cmp1_async_route: assert property (@(posedge sys_clk) disable iff (rst)
		s_write_a |=> cmp1_async_out_route == $past(sfr_wdata[7]))
		else $error("comparator 1 async route does not follow its bit");

	a_cmp_sync_routes: assert property (@(posedge sys_clk) disable iff (rst)
		s_write_a |=> cmp1_sync_out_route == $past(sfr_wdata[6])
			&& cmp0_sync_out_route == $past(sfr_wdata[4]))
		else $error("comparator sync routes do not follow their bits");

	a_cmp0_async_route: assert property (@(posedge sys_clk) disable iff (rst)
		s_write_a |=> cmp0_async_out_route == $past(sfr_wdata[5]))
		else $error("comparator 0 async route does not follow its bit");

	a_pairs_together: assert property (@(posedge sys_clk) disable iff (rst)
		twowire_data_route == twowire_clock_route && fieldbus_tx_route == fieldbus_rx_route
			&& async_serial_tx_route == async_serial_rx_route)
		else $error("paired signals routed apart");

	a_pair_enables: assert property (@(posedge sys_clk) disable iff (rst)
		s_write_a |=> twowire_data_route == $past(sfr_wdata[3])
			&& fieldbus_tx_route == $past(sfr_wdata[1])
			&& async_serial_tx_route == $past(sfr_wdata[0]))
		else $error("paired peripheral route does not follow its bit");

	a_select_mode: assert property (@(posedge sys_clk) disable iff (rst)
		s_write_a ##0 (slave_select_mode == CXR_SELECT_3WIRE)
			|=> serial_periph_route == $past(sfr_wdata[2]) && !serial_select_route)
		else $error("serial peripheral or select route wrong");

	a_timer_routes: assert property (@(posedge sys_clk) disable iff (rst)
		s_write_b |=> timer1_input_route == $past(sfr_wdata[7])
			&& timer0_input_route == $past(sfr_wdata[6])
			&& counter_ext_clock_route == $past(sfr_wdata[5])
			&& sysclock_out_route == $past(sfr_wdata[1]))
		else $error("second register route bits not followed");

	a_channel_count: assert property (@(posedge sys_clk) disable iff (rst)
		s_write_b ##0 (sfr_wdata[4:2] == CXR_CHAN_ALL) |=> counter_channel_pin_n_route == 6'h3F
			##1 (counter_channel_pin_n_route == 6'h3F || $past(sfr_wr) || !$past(crossbar_global_on)))
		else $error("channel count six does not route all channels");

	a_global_off: assert property (@(posedge sys_clk) disable iff (rst)
		!crossbar_global_on |=> pins_port_input_only && counter_channel_pin_n_route == '0
			&& !cmp1_async_out_route && !serial_periph_route && !sysclock_out_route)
		else $error("route active while crossbar off");

	a_reset_clear: assert property (@(posedge sys_clk)
		rst |=> !cmp1_async_out_route && !timer1_input_route && counter_channel_pin_n_route == '0
			&& sfr_rdata == 8'h00)
		else $error("routes not cleared by reset");

endmodule // cxr_routing

// *** src/cxr_pkg.sv ***
// Constants for the crossbar peripheral routing enables block.
// Assumes an 8-bit special-function-register bus with byte addresses.
package cxr_pkg;

	// Register byte addresses on the special-function-register bus.
	localparam logic [7:0] CXR_ROUTE_A_ADDR = 8'hE1;
	localparam logic [7:0] CXR_ROUTE_B_ADDR = 8'hE2;

	// Values after reset, and the read data for unmapped addresses.
	localparam logic [7:0] CXR_ROUTE_A_RESET = 8'h00;
	localparam logic [7:0] CXR_ROUTE_B_RESET = 8'h00;
	localparam logic [7:0] CXR_RDATA_RESET = 8'h00;
	localparam logic [7:0] CXR_UNMAPPED_DATA = 8'h00;

	// Field positions of the first routing register.
	localparam int CXR_A_CMP1_ASYNC = 7;
	localparam int CXR_A_CMP1_SYNC = 6;
	localparam int CXR_A_CMP0_ASYNC = 5;
	localparam int CXR_A_CMP0_SYNC = 4;
	localparam int CXR_A_TWOWIRE = 3;
	localparam int CXR_A_SERIAL_PERIPH = 2;
	localparam int CXR_A_FIELDBUS = 1;
	localparam int CXR_A_ASYNC_SERIAL = 0;

	// Field positions of the second routing register.
	localparam int CXR_B_TIMER1 = 7;
	localparam int CXR_B_TIMER0 = 6;
	localparam int CXR_B_EXT_CLOCK = 5;
	localparam int CXR_B_CHAN_HI = 4;
	localparam int CXR_B_CHAN_LO = 2;
	localparam int CXR_B_SYSCLOCK = 1;
	localparam int CXR_B_SPARE = 0;

	// Counter-array channel field.
	localparam int CXR_CHAN_W = 3;
	localparam int CXR_CHANNELS = 6;
	localparam logic [2:0] CXR_CHAN_NONE = 3'h0;
	localparam logic [2:0] CXR_CHAN_ALL = 3'h6;
	localparam logic [2:0] CXR_CHAN_RESERVED = 3'h7;

	// Slave-select mode code for 3-wire operation, where no select pin is used.
	localparam logic [1:0] CXR_SELECT_3WIRE = 2'h0;

endpackage

// *** src/cxr_channel_decode.sv ***
// Turns the counter-array channel count into a per-channel route mask.
// Assumes the count is a settled combinational value from the caller.
`timescale 1ns/1ps

module cxr_channel_decode import cxr_pkg::*; (
	input wire logic [CXR_CHAN_W-1:0] count,
	output logic [CXR_CHANNELS-1:0] mask
);

	always_comb begin
		mask = '0;
		// The reserved code routes nothing, so a bad write cannot grab extra pins.
		if (count != CXR_CHAN_RESERVED) begin
			for (int i = 0; i < CXR_CHANNELS; i++) begin
				mask[i] = (3'(i) < count);
			end
		end
	end

endmodule // cxr_channel_decode

// *** verification/cxr_routing_tb.sv ***
// Self-checking testbench for the crossbar routing registers and route enables.
// Assumes the design takes bus strobes at the rising edge and registers every output.
`timescale 1ns/1ps

module cxr_routing_tb import cxr_pkg::*; ;
	typedef struct packed {
		logic [7:0] data;
		logic [22:0] routes;
	} cxr_note_t;

	logic sys_clk, rst, sfr_wr, sfr_rd, crossbar_global_on;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, reg_a, reg_b, d;
	logic [1:0] slave_select_mode;
	wire [22:0] routes;
	cxr_note_t notes[$];
	cxr_note_t note;
	int errors, check_count, k;

	cxr_routing cxr_routing_inst (.sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.crossbar_global_on(crossbar_global_on), .slave_select_mode(slave_select_mode),
		.pins_port_input_only(routes[22]), .cmp1_async_out_route(routes[21]),
		.cmp1_sync_out_route(routes[20]), .cmp0_async_out_route(routes[19]),
		.cmp0_sync_out_route(routes[18]), .twowire_data_route(routes[17]),
		.twowire_clock_route(routes[16]), .serial_periph_route(routes[15]),
		.serial_select_route(routes[14]), .fieldbus_tx_route(routes[13]),
		.fieldbus_rx_route(routes[12]), .async_serial_tx_route(routes[11]),
		.async_serial_rx_route(routes[10]), .timer1_input_route(routes[9]),
		.timer0_input_route(routes[8]), .counter_ext_clock_route(routes[7]),
		.counter_channel_pin_n_route(routes[6:1]), .sysclock_out_route(routes[0]));

	function automatic logic [22:0] exp_routes(logic [7:0] a, logic [7:0] b, logic g,
		logic [1:0] m);
		logic [5:0] ch;
		ch = (b[4:2] == CXR_CHAN_RESERVED) ? 6'h00 : 6'((7'h01 << b[4:2]) - 7'h01);
		if (!g) return {1'b1, 22'h000000};
		return {1'b0, a[7:4], {2{a[3]}}, a[2], a[2] & (m != CXR_SELECT_3WIRE), {2{a[1]}},
			{2{a[0]}}, b[7:5], ch, b[1]};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One bus cycle; a read notes the old register value and routes that follow any write.
	task automatic bus(input logic w, input logic r, input logic [7:0] addr,
		input logic [7:0] data);
		logic [7:0] na, nb;
		na = (w && addr == CXR_ROUTE_A_ADDR) ? data : reg_a;
		nb = (w && addr == CXR_ROUTE_B_ADDR) ? data : reg_b;
		if (r) notes.push_back({(addr == CXR_ROUTE_A_ADDR) ? reg_a :
			(addr == CXR_ROUTE_B_ADDR) ? reg_b : CXR_UNMAPPED_DATA,
			exp_routes(na, nb, crossbar_global_on, slave_select_mode)});
		reg_a = na;
		reg_b = nb;
		sfr_wr = w;
		sfr_rd = r;
		sfr_addr = addr;
		sfr_wdata = data;
		@(negedge sys_clk);
	endtask

	task automatic do_reset;
		rst = 1'b1;
		repeat (3) @(negedge sys_clk);
		rst = 1'b0;
		reg_a = CXR_ROUTE_A_RESET;
		reg_b = CXR_ROUTE_B_RESET;
	endtask

	task automatic summarize;
		$display("Comparisons %0d, errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	always @(posedge sys_clk) begin
		if (sfr_rd === 1'b1 && rst === 1'b0) begin
			#1;
			note = notes.pop_front();
			check(32'(sfr_rdata), 32'(note.data));
			check(32'(routes[21:10]), 32'(note.routes[21:10]));
			check(32'(routes[9:0]), 32'(note.routes[9:0]));
			check(32'(routes[22]), 32'(note.routes[22]));
		end
	end

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	// The tests take well under two thousand cycles; ten thousand means a hang.
	initial begin
		#50000;
		errors++;
		summarize();
	end

	initial begin
		{sfr_wr, sfr_rd, sfr_addr, sfr_wdata, crossbar_global_on, slave_select_mode} = '0;
		void'($urandom(1));
		do_reset();
		bus(1'b0, 1'b1, CXR_ROUTE_A_ADDR, 8'h00);
		crossbar_global_on = 1'b1;
		bus(1'b0, 1'b1, CXR_ROUTE_B_ADDR, 8'h00);
		for (int i = 0; i < 8; i++) bus(1'b1, 1'b1, CXR_ROUTE_A_ADDR, 8'(1 << i));
		bus(1'b1, 1'b1, CXR_ROUTE_A_ADDR, 8'h04);
		for (int m = 0; m < 4; m++) begin
			slave_select_mode = 2'(m);
			bus(1'b0, 1'b1, CXR_ROUTE_A_ADDR, 8'h00);
		end
		crossbar_global_on = 1'b0;
		bus(1'b1, 1'b1, CXR_ROUTE_A_ADDR, 8'hFF);
		crossbar_global_on = 1'b1;
		bus(1'b0, 1'b1, CXR_ROUTE_A_ADDR, 8'h00);
		// Every legal channel count, from none up to all six channels.
		for (int c = 0; c < 7; c++) bus(1'b1, 1'b1, CXR_ROUTE_B_ADDR, {3'h5, 3'(c), 2'h2});
		bus(1'b1, 1'b0, 8'hE3, 8'hFF);
		bus(1'b0, 1'b1, 8'hE3, 8'h00);
		bus(1'b0, 1'b1, CXR_ROUTE_B_ADDR, 8'h00);
		repeat (200) begin
			k = $urandom_range(2, 0);
			d = 8'($urandom);
			if (k == 1 && d[4:2] == CXR_CHAN_RESERVED) d[4:2] = CXR_CHAN_ALL;
			if (k == 1) d[CXR_B_SPARE] = 1'b0;
			crossbar_global_on = ($urandom_range(3, 0) != 0);
			slave_select_mode = 2'($urandom);
			// Unmapped addresses stay below both registers, so random data never
			// lands in the second register with a reserved code or spare bit set.
			bus(1'($urandom), 1'($urandom), (k == 0) ? CXR_ROUTE_A_ADDR :
				(k == 1) ? CXR_ROUTE_B_ADDR : {1'b0, 7'($urandom)}, d);
		end
		bus(1'b1, 1'b0, CXR_ROUTE_A_ADDR, 8'hFF);
		bus(1'b0, 1'b0, 8'h00, 8'h00);
		do_reset();
		bus(1'b0, 1'b1, CXR_ROUTE_A_ADDR, 8'h00);
		bus(1'b0, 1'b1, CXR_ROUTE_B_ADDR, 8'h00);
		bus(1'b0, 1'b0, 8'h00, 8'h00);
		repeat (2) @(negedge sys_clk);
		summarize();
	end
endmodule // cxr_routing_tb
